/* verilog/dac_serial_map.svh */
// Constants for the quad DAC serial load control block.
// Assumes inclusion by its bare name from the package and the top module.
`ifndef DAC_SERIAL_MAP_SVH
`define DAC_SERIAL_MAP_SVH

// Serial frame layout, bit 0 is the last bit shifted in
`define FRAME_BITS 24
`define FLD_DATA_LSB 0
`define FLD_DATA_W 14
`define FLD_CHAN_LSB 14
`define FLD_CHAN_W 2
`define FLD_PKG_LSB 16
`define FLD_PKG_W 5
`define NUM_CHANNELS 4

// Register byte offsets on the APB slave
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_FRAMES 12'h008
`define OFS_DROPS 12'h00c
`define OFS_INREG_BASE 12'h010
`define OFS_LATCH_BASE 12'h020

// Control register fields and reset value
`define CTRL_LINK_EN 0
`define CTRL_SW_LOAD 1
`define CTRL_RESET 32'h00000001

// Status register fields
`define ST_CLAMP 0
`define ST_STROBE_N 1
`define ST_CLEAR_N 2
`define ST_FRAME_SYNC_N_N 3
`define ST_PKG_ADDR_ENABLE 4

// Timing: least strobe or clear pulse width and the clock period
`define T_PULSE_MIN_NS 40
`define CLK_PERIOD_NS 50
`define PULSE_MIN_CYC \
  ((`T_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* verilog/dac_serial_pkg.sv */
// Types shared by the quad DAC serial load control block.
// Assumes the constant header is on the include path.
`include "dac_serial_map.svh"

package dac_serial_pkg;
  typedef logic [`FLD_DATA_W-1:0] code_t;
  typedef logic [`FLD_CHAN_W-1:0] chan_t;
  typedef logic [`FLD_PKG_W-1:0] pkg_addr_t;
  typedef logic [`FRAME_BITS-1:0] frame_t;

  // Register selected by an APB address
  typedef enum {
    REG_CTRL,
    REG_STATUS,
    REG_FRAMES,
    REG_DROPS,
    REG_INREG,
    REG_LATCH,
    REG_NONE
  } reg_sel_e;
endpackage

/* verilog/dac_sync2.sv */
// Two-stage level synchroniser for a group of pin inputs.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/100ps

module dac_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else if (i_clk_en)
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

/* verilog/quad_dac_serial_load_control.sv */
// Digital control of a quad 14-bit DAC with a serial load port.
// Assumes the serial clock, data and frame sync come from one host, with
// data and frame sync changing away from falling serial clock edges; the
// remaining pins are slow levels; software uses an APB master.
//
// Behaviour
// - Serial data is shifted in on each falling serial clock edge of an open frame.
// - Frame sync is active low and bits are taken only while it is low.
// - The rising edge of frame sync moves the frame's 14-bit code to an input register.
// - With package addressing off, the frame package address is honoured.
// - With package addressing on, any package loads the addressed channel.
// - While the load strobe is high, no DAC latch or output code changes except on a software load.
// - With the load strobe low, all four input registers go to the latches together.
// - A low clear forces all outputs to sense ground without any clock.
// - After clear rises, outputs stay at sense ground until the strobe is low or software requests a load.
// - While clear is low, the load strobe is ignored.
`timescale 1ns/100ps
`include "dac_serial_map.svh"

module quad_dac_serial_load_control
  import dac_serial_pkg::*;
#(
  parameter int CHANNELS = `NUM_CHANNELS,
  parameter int FRAME_W = `FRAME_BITS,
  parameter int DATA_LSB = `FLD_DATA_LSB,
  parameter int CHAN_LSB = `FLD_CHAN_LSB,
  parameter int PKG_LSB = `FLD_PKG_LSB,
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial link, clocked by the host
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_frame_sync_n,
  // Static and slow pins
  input wire logic [`FLD_PKG_W-1:0] i_pkg_addr_pins,
  input wire logic i_pkg_addr_enable,
  input wire logic i_load_latch_strobe_n,
  input wire logic i_async_clear_n,
  // DAC codes and the sense ground select of the analog stage
  output logic [CHANNELS*`FLD_DATA_W-1:0] o_analog_outputs,
  output logic o_output_at_sense_ground
);

  localparam int SYNC_W = `FLD_PKG_W + 4;
  localparam logic [3:0] PULSE_CYC = 4'(`PULSE_MIN_CYC);
  localparam logic [SYNC_W-1:0] SYNC_RST = {4'b1110, {`FLD_PKG_W{1'b0}}};

  // Decode an APB address into a register and is used by reads and writes
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = REG_NONE;
    if (addr[1:0] == 2'b00)
    begin
      if (addr == ADDR_W'(`OFS_CTRL))
        sel = REG_CTRL;
      else if (addr == ADDR_W'(`OFS_STATUS))
        sel = REG_STATUS;
      else if (addr == ADDR_W'(`OFS_FRAMES))
        sel = REG_FRAMES;
      else if (addr == ADDR_W'(`OFS_DROPS))
        sel = REG_DROPS;
      else if ((addr & ~ADDR_W'(12'h00f)) == ADDR_W'(`OFS_INREG_BASE))
        sel = REG_INREG;
      else if ((addr & ~ADDR_W'(12'h00f)) == ADDR_W'(`OFS_LATCH_BASE))
        sel = REG_LATCH;
    end
    return sel;
  endfunction

  // ---------------- Link domain, serial clock ----------------

  frame_t shift_q;

  // Shift only while the frame is open; idle edges leave the word still
  always_ff @(negedge i_sclk or posedge i_rst)
  begin
    if (i_rst)
      shift_q <= '0;
    else if (!i_frame_sync_n)
      shift_q <= {shift_q[FRAME_W-2:0], i_sdata};
  end

  // ---------------- Pin synchronisers ----------------

  logic [SYNC_W-1:0] pins_sync;
  logic frame_sync_n_s;
  logic clear_s;
  logic strobe_s;
  logic pkg_addr_enable_s;
  pkg_addr_t pkg_pins_s;

  dac_sync2 #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RST)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_async({i_frame_sync_n, i_async_clear_n, i_load_latch_strobe_n,
              i_pkg_addr_enable, i_pkg_addr_pins}),
    .o_sync(pins_sync)
  );

  // Unpack the synchronised levels
  assign frame_sync_n_s = pins_sync[SYNC_W-1];
  assign clear_s = pins_sync[SYNC_W-2];
  assign strobe_s = pins_sync[SYNC_W-3];
  assign pkg_addr_enable_s = pins_sync[SYNC_W-4];
  assign pkg_pins_s = pins_sync[`FLD_PKG_W-1:0];

  // ---------------- Frame capture ----------------

  logic frame_sync_n_prev_q;
  logic frame_end;
  logic pkg_match;
  logic frame_ok;
  logic frame_take;
  chan_t frame_chan;
  code_t frame_data;
  pkg_addr_t frame_pkg;
  logic link_en;

  // Frame end is seen two or three clocks late; by then the serial clock
  // can no longer shift because frame sync is high, so the word is still
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      frame_sync_n_prev_q <= 1'b1;
    else if (i_clk_en)
      frame_sync_n_prev_q <= frame_sync_n_s;
  end

  assign frame_end = frame_sync_n_s & ~frame_sync_n_prev_q;

  // Field extraction at set positions
  assign frame_data = shift_q[DATA_LSB +: `FLD_DATA_W];
  assign frame_chan = shift_q[CHAN_LSB +: `FLD_CHAN_W];
  assign frame_pkg = shift_q[PKG_LSB +: `FLD_PKG_W];

  // Package filter against the strapped pins
  assign pkg_match = (frame_pkg == pkg_pins_s);
  assign frame_ok = pkg_addr_enable_s | pkg_match;
  assign frame_take = frame_end & link_en & frame_ok;

  // ---------------- Input registers and DAC latches ----------------

  code_t inreg_q [CHANNELS];
  code_t latch_q [CHANNELS];
  logic [3:0] strobe_low_q;
  logic strobe_ok;
  logic sw_load_q;
  logic load_now;

  // Strobe must be low for the least pulse width before it loads
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      strobe_low_q <= 4'h0;
    else if (i_clk_en)
    begin
      if (strobe_s)
        strobe_low_q <= 4'h0;
      else if (strobe_low_q != PULSE_CYC)
        strobe_low_q <= strobe_low_q + 4'h1;
    end
  end

  assign strobe_ok = (strobe_low_q == PULSE_CYC);

  // Level sensitive load, blocked while clear is low
  assign load_now = clear_s & (strobe_ok | sw_load_q);

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      // Only the addressed channel takes a new frame
      always_ff @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
          inreg_q[ch] <= '0;
        else if (i_clk_en && frame_take && frame_chan == chan_t'(ch))
          inreg_q[ch] <= frame_data;
      end

      // All latches share one load term so they move together
      always_ff @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
          latch_q[ch] <= '0;
        else if (i_clk_en && load_now)
          latch_q[ch] <= inreg_q[ch];
      end

      assign o_analog_outputs[ch*`FLD_DATA_W +: `FLD_DATA_W] = latch_q[ch];
    end
  endgenerate

  // ---------------- Sense ground clamp ----------------

  logic clamp_q;

  // Clear sets the clamp with no clock at all; release waits for a load
  // with clear seen high, and the release edge is kept off the async pin
  always_ff @(posedge i_clock or posedge i_rst or negedge i_async_clear_n)
  begin
    if (i_rst)
      clamp_q <= 1'b1;
    else if (!i_async_clear_n)
      clamp_q <= 1'b1;
    else if (i_clk_en && load_now)
      clamp_q <= 1'b0;
  end

  assign o_output_at_sense_ground = clamp_q;

  // ---------------- Counters ----------------

  logic [CNT_W-1:0] frames_q;
  logic [CNT_W-1:0] drops_q;

  // Accepted frames, wrapping
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      frames_q <= '0;
    else if (i_clk_en && frame_take)
      frames_q <= frames_q + CNT_W'(1);
  end

  // Frames dropped by the package filter or a disabled link
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      drops_q <= '0;
    else if (i_clk_en && frame_end && !frame_take)
      drops_q <= drops_q + CNT_W'(1);
  end

  // ---------------- APB slave ----------------

  logic [31:0] ctrl_q;
  logic apb_access;
  logic apb_write;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;
  logic [1:0] rd_idx;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  // Freezing the clock also stalls the bus, so nothing is lost
  assign o_pready = i_clk_en;
  assign apb_access = i_psel & i_penable & i_clk_en;
  assign apb_write = apb_access & i_pwrite;
  assign wr_sel = decode(i_paddr);
  assign rd_sel = decode(i_paddr);
  assign rd_idx = i_paddr[3:2];
  assign o_pslverr = apb_access & (wr_sel == REG_NONE);
  assign link_en = ctrl_q[`CTRL_LINK_EN];

  // Control register; the load bit is not stored
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      ctrl_q <= `CTRL_RESET;
    else if (apb_write && wr_sel == REG_CTRL)
      ctrl_q <= {31'h00000000, i_pwdata[`CTRL_LINK_EN]};
  end

  // Software load request lasts exactly one clock
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      sw_load_q <= 1'b0;
    else if (i_clk_en)
      sw_load_q <= apb_write && wr_sel == REG_CTRL &&
                   i_pwdata[`CTRL_SW_LOAD];
  end

  // Live pin and clamp levels
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[`ST_CLAMP] = clamp_q;
    status_word[`ST_STROBE_N] = strobe_s;
    status_word[`ST_CLEAR_N] = clear_s;
    status_word[`ST_FRAME_SYNC_N_N] = frame_sync_n_s;
    status_word[`ST_PKG_ADDR_ENABLE] = pkg_addr_enable_s;
  end

  // Read multiplexer
  always_comb
  begin
    case (rd_sel)
      REG_CTRL:
        rd_mux = ctrl_q;
      REG_STATUS:
        rd_mux = status_word;
      REG_FRAMES:
        rd_mux = 32'(frames_q);
      REG_DROPS:
        rd_mux = 32'(drops_q);
      REG_INREG:
        rd_mux = 32'(inreg_q[rd_idx]);
      REG_LATCH:
        rd_mux = 32'(latch_q[rd_idx]);
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // Read data is sampled every selected cycle, so it is valid from the
  // first access cycle; it lags live state by one clock
  // Limitation: a read whose setup edge falls while the enable is low
  // returns data from before the stall; keep the enable high for reads
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_prdata <= 32'h00000000;
    else if (i_clk_en)
      o_prdata <= (i_psel && !i_pwrite) ? rd_mux : 32'h00000000;
  end

endmodule

/* tb/dac_host_model.sv */
// Serial host model that drives frames onto the link pins.
// Assumes the bench calls send() with the half period of the link clock.
`timescale 1ns/100ps
module dac_host;
  logic sclk = 1;
  logic sdata = 0;
  logic frame_sync_n_n = 1;
  // Clock idles high between frames; bits go MSB first
  task automatic send(input logic [23:0] f, input realtime half);
    #(13.7); // Keeps link edges off the system clock phase
    frame_sync_n_n = 0;
    #(half);
    for (int i = 23; i >= 0; i--)
    begin
      sdata = f[i]; // Changes well away from the falling edge
      #(half);
      sclk = 0;
      #(half);
      sclk = 1;
    end
    #(half);
    frame_sync_n_n = 1;
    sdata = ~sdata; // Released line must not show the last bit
    #(300); // Quiet gap so the frame can cross domains
  endtask
endmodule

/* tb/quad_dac_serial_load_control_sva.sv */
// Assertion checker for the quad DAC serial load control block.
// Assumes it is bound to the top module with its default widths.
`timescale 1ns/100ps
module dac_load_sva (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_load_latch_strobe_n,
  input wire logic i_async_clear_n,
  input wire logic [55:0] o_analog_outputs,
  input wire logic o_output_at_sense_ground
);
  logic [4:0] lo_q;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Runs long enough to cover the pin synchronisers
  sequence strobe_idle;
    i_load_latch_strobe_n [*6];
  endsequence
  sequence clear_held;
    !i_async_clear_n [*4];
  endsequence
  // Recent history of a low strobe pin
  always_ff @(posedge i_clock or posedge i_rst)
    if (i_rst)
      lo_q <= '0;
    else
      lo_q <= {lo_q[3:0], !i_load_latch_strobe_n};
  chk_clear_clamp: assert property (
    !i_async_clear_n |-> o_output_at_sense_ground)
    else $error("outputs left sense ground during clear");
  chk_clear_freeze: assert property (
    clear_held |-> $stable(o_analog_outputs))
    else $error("latch moved while clear held");
  chk_strobe_freeze: assert property (
    strobe_idle |-> $stable(o_analog_outputs))
    else $error("latch moved while strobe high");
  chk_clamp_release: assert property (
    $fell(o_output_at_sense_ground) |->
      i_async_clear_n && $past(i_async_clear_n, 2) && |lo_q)
    else $error("clamp released without load");
  chk_pready_enable: assert property (o_pready == i_clk_en)
    else $error("pready differs from clock enable");
  chk_err_phase: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slave error outside access phase");
  chk_misalign_err: assert property (
    i_psel && i_penable && o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
    else $error("misaligned access not refused");
  chk_err_read_zero: assert property (
    i_psel && i_penable && !i_pwrite && o_pslverr |-> o_prdata == '0)
    else $error("refused read returned data");
endmodule

bind quad_dac_serial_load_control dac_load_sva dac_load_sva_inst (
  .i_clock, .i_rst, .i_clk_en, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .i_load_latch_strobe_n,
  .i_async_clear_n, .o_analog_outputs, .o_output_at_sense_ground);

/* tb/test_quad_dac_serial_load_control.sv */
// Self-checking bench for the quad DAC serial load control block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
module test_quad_dac_serial_load_control import dac_serial_pkg::*;;
  logic i_clock = 0, i_rst = 1, i_clk_en = 1, i_psel = 0;
  logic i_penable = 0, i_pwrite = 0, i_pkg_addr_enable = 0;
  logic i_load_latch_strobe_n = 1, i_async_clear_n = 1;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, r;
  logic o_pready, o_pslverr, o_output_at_sense_ground, e;
  logic [55:0] o_analog_outputs, lat = '0;
  logic clamp = 1;
  pkg_addr_t i_pkg_addr_pins = '0;
  code_t inreg [4] = '{default: '0};
  int fails = 0, compares = 0, drops = 0, frames = 0;
  int seed = 32'hb72824ec;
  dac_host host();
  quad_dac_serial_load_control quad_dac_serial_load_control_inst (
    .i_clock, .i_rst, .i_clk_en, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_sclk(host.sclk), .i_sdata(host.sdata),
    .i_frame_sync_n(host.frame_sync_n_n), .i_pkg_addr_pins,
    .i_pkg_addr_enable, .i_load_latch_strobe_n, .i_async_clear_n,
    .o_analog_outputs, .o_output_at_sense_ground);
  initial
    forever #25 i_clock = ~i_clock;
  task automatic wrap_up();
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, x);
    compares++;
    if (g !== x)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_out(input logic [56:0] x);
    compares++;
    if ({o_output_at_sense_ground, o_analog_outputs} !== x)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
        {o_output_at_sense_ground, o_analog_outputs}, x);
    end
  endtask
  // APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, '0);
    chk_reg(r, x);
  endtask
  // One frame; the model decides whether it lands
  task automatic frame(input pkg_addr_t p, input realtime h);
    chan_t c;
    code_t d;
    c = chan_t'($random(seed));
    d = code_t'($random(seed));
    host.send({3'h0, p, c, d}, h);
    if (i_pkg_addr_enable || p === i_pkg_addr_pins)
    begin
      inreg[c] = d;
      frames++;
    end
    else
      drops++;
    repeat (4) @(posedge i_clock);
    chk_out({clamp, lat});
    rd({8'h01, c, 2'h0}, {18'h0, inreg[c]});
  endtask
  // Strobe pulse, long enough to pass the synchronisers
  task automatic load();
    @(posedge i_clock);
    i_load_latch_strobe_n <= 0;
    repeat (6) @(posedge i_clock);
    if (i_async_clear_n)
    begin
      for (int k = 0; k < 4; k++)
        lat[k*14 +: 14] = inreg[k];
      clamp = 0;
    end
    chk_out({clamp, lat});
    i_load_latch_strobe_n <= 1;
    repeat (6) @(posedge i_clock);
  endtask
  initial
  begin
    i_pkg_addr_pins = pkg_addr_t'($random(seed));
    repeat (16) @(posedge i_clock);
    i_rst <= 0;
    repeat (3) @(posedge i_clock);
    chk_out({clamp, lat});
    rd(12'h000, 32'h1);
    // Own, foreign and broadcast frames at the link rate
    for (int k = 0; k < 12; k++)
    begin
      if (k == 6)
        load();
      @(posedge i_clock);
      i_pkg_addr_enable <= k[2];
      frame(k[0] ? i_pkg_addr_pins : pkg_addr_t'($random(seed)),
        62.5);
    end
    rd(12'h008, frames);
    rd(12'h00c, drops);
    // Clear overrides the strobe until it is released
    @(posedge i_clock);
    i_async_clear_n <= 0;
    repeat (2) @(posedge i_clock);
    clamp = 1;
    chk_out({clamp, lat});
    load();
    i_async_clear_n <= 1;
    repeat (4) @(posedge i_clock);
    chk_out({clamp, lat});
    load();
    rd(12'h020, {18'h0, lat[13:0]});
    rd(12'h004, {27'h0, i_pkg_addr_enable, 3'h7, clamp});
    // Refused accesses and a stall
    apb(0, 12'h0f0, '0);
    chk_reg({r[30:0], e}, 32'h1);
    apb(1, 12'h002, 32'h0);
    chk_reg({31'h0, e}, 32'h1);
    // A write stalled by the clock enable lands once the enable returns
    i_clk_en <= 0;
    fork
      apb(1, 12'h000, 32'h0);
      begin
        repeat (3) @(posedge i_clock);
        chk_reg({31'h0, o_pready}, 32'h0);
        i_clk_en <= 1;
      end
    join
    rd(12'h000, 32'h0);
    chk_reg({31'h0, e}, 32'h0);
    wrap_up();
  end
  // Hang guard, well beyond the expected run
  initial
  begin
    #1ms;
    fails++;
    wrap_up();
  end
endmodule
